// *** hw/dsp_pkg.sv ***
// Shared constants and types for the dual-slope PWM timer.
package dsp_pkg;

  localparam int DATA_W = 16;
  localparam int ADDR_W = 3;
  localparam int DIV_W = 10;

  // Register offsets.
  localparam logic [2:0] ADDR_CTRL = 3'h0;
  localparam logic [2:0] ADDR_COUNT = 3'h1;
  localparam logic [2:0] ADDR_CMP_A = 3'h2;
  localparam logic [2:0] ADDR_CMP_B = 3'h3;
  localparam logic [2:0] ADDR_CAP_TOP = 3'h4;
  localparam logic [2:0] ADDR_FLAGS = 3'h5;
  localparam logic [2:0] ADDR_STATUS = 3'h6;

  // Control register fields.
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_ACT_A_LSB = 4;
  localparam int CTRL_ACT_B_LSB = 6;
  localparam int CTRL_DIR_A = 8;
  localparam int CTRL_DIR_B = 9;
  localparam int CTRL_PORT_A = 10;
  localparam int CTRL_PORT_B = 11;
  localparam int CTRL_PRE_LSB = 12;

  // Flag register fields.
  localparam int FLAG_OVF = 0;
  localparam int FLAG_CMP_A = 1;
  localparam int FLAG_CMP_B = 2;
  localparam int FLAG_CAP = 3;
  localparam int FLAG_W = 4;

  // Status register fields.
  localparam int STAT_UP = 0;
  localparam int STAT_OUT_A = 1;
  localparam int STAT_OUT_B = 2;

  // Reset values.
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [15:0] VALUE_RST = 16'h0000;
  localparam logic [3:0] FLAGS_RST = 4'h0;

  // Waveform mode codes.
  localparam logic [3:0] MODE_PC_8 = 4'h1;
  localparam logic [3:0] MODE_PC_9 = 4'h2;
  localparam logic [3:0] MODE_PC_10 = 4'h3;
  localparam logic [3:0] MODE_PFC_CAP = 4'h8;
  localparam logic [3:0] MODE_PFC_CMPA = 4'h9;
  localparam logic [3:0] MODE_PC_CAP = 4'hA;
  localparam logic [3:0] MODE_PC_CMPA = 4'hB;

  // Count limits.
  localparam logic [15:0] BOTTOM = 16'h0000;
  localparam logic [15:0] TOP_8 = 16'h00FF;
  localparam logic [15:0] TOP_9 = 16'h01FF;
  localparam logic [15:0] TOP_10 = 16'h03FF;
  localparam logic [15:0] TOP_MAX = 16'hFFFF;

  // Output action codes.
  localparam logic [1:0] ACT_OFF = 2'h0;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_NONINV = 2'h2;
  localparam logic [1:0] ACT_INV = 2'h3;

  // Prescale selects and the divider masks they use.
  localparam logic [2:0] PRE_DIV_1 = 3'h1;
  localparam logic [2:0] PRE_DIV_8 = 3'h2;
  localparam logic [2:0] PRE_DIV_64 = 3'h3;
  localparam logic [2:0] PRE_DIV_256 = 3'h4;
  localparam logic [2:0] PRE_DIV_1024 = 3'h5;
  localparam logic [9:0] MASK_DIV_1 = 10'h000;
  localparam logic [9:0] MASK_DIV_8 = 10'h007;
  localparam logic [9:0] MASK_DIV_64 = 10'h03F;
  localparam logic [9:0] MASK_DIV_256 = 10'h0FF;
  localparam logic [9:0] MASK_DIV_1024 = 10'h3FF;

  typedef enum logic {
    DSP_DIR_UP = 1'b0,
    DSP_DIR_DOWN = 1'b1
  } dsp_dir_e;

endpackage

// *** hw/dsp_channel.sv ***
// One compare channel: match detection and output action.
`timescale 1ns/1ps

module dsp_channel
(
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_tick,
  input wire logic i_dual,
  input wire logic [15:0] i_count,
  input wire logic [15:0] i_compare,
  input wire logic i_next_up,
  input wire logic [1:0] i_action,
  input wire logic i_toggle_ok,
  output logic o_match,
  output logic o_compare_output
);

  logic out_q;
  logic out_d;

  //----------------------------------------------------------------
  // Match and output action
  //----------------------------------------------------------------
  // The direction used is the one after this step, so a match at zero
  // counts as rising and a match at top as falling; this makes a compare
  // of zero a steady low and a compare of top a steady high in non-inverting mode.
  always_comb
  begin
    o_match = i_tick && i_dual && (i_count == i_compare);
    out_d = out_q;
    if (o_match)
    begin
      case (i_action)
        dsp_pkg::ACT_TOGGLE:
        begin
          if (i_toggle_ok)
          begin
            out_d = ~out_q;
          end
        end
        dsp_pkg::ACT_NONINV: out_d = ~i_next_up;
        dsp_pkg::ACT_INV: out_d = i_next_up;
        default: out_d = out_q;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      out_q <= 1'b0;
    end
    else
    begin
      out_q <= out_d;
    end
  end

  assign o_compare_output = out_q;

endmodule

// *** hw/dsp_timer.sv ***
// Dual-slope PWM timer with two compare channels and a plain register port.
//
// Chosen here: the address map and the address-and-strobe port.
`timescale 1ns/1ps

module dsp_timer
(
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic [2:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [15:0] o_rdata,
  output logic o_pin_a,
  output logic o_pin_a_oe_n,
  output logic o_pin_b,
  output logic o_pin_b_oe_n
);

  //----------------------------------------------------------------
  // Declarations
  //----------------------------------------------------------------
  logic [9:0] div_q;
  logic [9:0] div_d;
  logic [9:0] div_mask;
  logic div_on;
  logic tick;

  logic [15:0] ctrl_q;
  logic [15:0] ctrl_d;
  logic [15:0] count_value_q;
  logic [15:0] count_value_d;
  dsp_pkg::dsp_dir_e dir_q;
  dsp_pkg::dsp_dir_e dir_d;
  dsp_pkg::dsp_dir_e dir_next;
  logic [15:0] buf_a_q;
  logic [15:0] buf_a_d;
  logic [15:0] buf_b_q;
  logic [15:0] buf_b_d;
  logic [15:0] compare_value_a_q;
  logic [15:0] compare_value_a_d;
  logic [15:0] compare_value_b_q;
  logic [15:0] compare_value_b_d;
  logic [15:0] capture_top_value_q;
  logic [15:0] capture_top_value_d;
  logic [3:0] flags_q;
  logic [3:0] flags_d;
  logic [3:0] flag_set;
  logic [3:0] flag_clr;
  logic [15:0] rdata_d;
  logic pin_a_d;
  logic pin_b_d;

  logic [3:0] waveform_mode_sel;
  logic [1:0] output_action_sel_a;
  logic [1:0] output_action_sel_b;
  logic [2:0] pre_sel;
  logic mode_pc;
  logic mode_pfc;
  logic mode_dual;
  logic mode_fixed;
  logic top_is_cap;
  logic top_is_cmpa;
  logic [15:0] top;
  logic [15:0] write_mask;
  logic at_top;
  logic at_bottom;
  logic load;
  logic next_up;
  logic match_a;
  logic match_b;
  logic compare_output_a;
  logic compare_output_b;

  assign waveform_mode_sel = ctrl_q[dsp_pkg::CTRL_MODE_LSB +: 4];
  assign output_action_sel_a = ctrl_q[dsp_pkg::CTRL_ACT_A_LSB +: 2];
  assign output_action_sel_b = ctrl_q[dsp_pkg::CTRL_ACT_B_LSB +: 2];
  assign pre_sel = ctrl_q[dsp_pkg::CTRL_PRE_LSB +: 3];

  //----------------------------------------------------------------
  // Prescaler
  //----------------------------------------------------------------
  always_comb
  begin
    div_on = 1'b1;
    case (pre_sel)
      dsp_pkg::PRE_DIV_1: div_mask = dsp_pkg::MASK_DIV_1;
      dsp_pkg::PRE_DIV_8: div_mask = dsp_pkg::MASK_DIV_8;
      dsp_pkg::PRE_DIV_64: div_mask = dsp_pkg::MASK_DIV_64;
      dsp_pkg::PRE_DIV_256: div_mask = dsp_pkg::MASK_DIV_256;
      dsp_pkg::PRE_DIV_1024: div_mask = dsp_pkg::MASK_DIV_1024;
      default:
      begin
        div_mask = dsp_pkg::MASK_DIV_1;
        div_on = 1'b0;
      end
    endcase
    div_d = div_q + 10'h001;
    tick = div_on && ((div_q & div_mask) == 10'h000);
  end

  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      div_q <= 10'h000;
    end
    else
    begin
      div_q <= div_d;
    end
  end

  //----------------------------------------------------------------
  // Mode decode and top selection
  //----------------------------------------------------------------
  always_comb
  begin
    mode_pc = (waveform_mode_sel == dsp_pkg::MODE_PC_8) || (waveform_mode_sel == dsp_pkg::MODE_PC_9)
      || (waveform_mode_sel == dsp_pkg::MODE_PC_10) || (waveform_mode_sel == dsp_pkg::MODE_PC_CAP)
      || (waveform_mode_sel == dsp_pkg::MODE_PC_CMPA);
    mode_pfc = (waveform_mode_sel == dsp_pkg::MODE_PFC_CAP)
      || (waveform_mode_sel == dsp_pkg::MODE_PFC_CMPA);
    mode_dual = mode_pc || mode_pfc;
    top_is_cap = (waveform_mode_sel == dsp_pkg::MODE_PC_CAP) || (waveform_mode_sel == dsp_pkg::MODE_PFC_CAP);
    top_is_cmpa = (waveform_mode_sel == dsp_pkg::MODE_PC_CMPA) || (waveform_mode_sel == dsp_pkg::MODE_PFC_CMPA);
    mode_fixed = 1'b1;
    case (waveform_mode_sel)
      dsp_pkg::MODE_PC_8: top = dsp_pkg::TOP_8;
      dsp_pkg::MODE_PC_9: top = dsp_pkg::TOP_9;
      dsp_pkg::MODE_PC_10: top = dsp_pkg::TOP_10;
      dsp_pkg::MODE_PC_CAP, dsp_pkg::MODE_PFC_CAP:
      begin
        top = capture_top_value_q;
        mode_fixed = 1'b0;
      end
      dsp_pkg::MODE_PC_CMPA, dsp_pkg::MODE_PFC_CMPA:
      begin
        top = compare_value_a_q;
        mode_fixed = 1'b0;
      end
      default:
      begin
        top = dsp_pkg::TOP_MAX;
        mode_fixed = 1'b0;
      end
    endcase
    write_mask = mode_fixed ? top : dsp_pkg::TOP_MAX;
    at_top = (count_value_q == top);
    at_bottom = (count_value_q == dsp_pkg::BOTTOM);
  end

  //----------------------------------------------------------------
  // Dual-slope counter
  //----------------------------------------------------------------
  // Top is shown for one tick before the count turns; a top lowered below
  // the count lets the counter run on through the wrap to zero.
  always_comb
  begin
    dir_next = dir_q;
    if (at_top)
    begin
      dir_next = dsp_pkg::DSP_DIR_DOWN;
    end
    else if (at_bottom)
    begin
      dir_next = dsp_pkg::DSP_DIR_UP;
    end
    next_up = (dir_next == dsp_pkg::DSP_DIR_UP);
    count_value_d = count_value_q;
    dir_d = dir_q;
    if (i_wr && (i_addr == dsp_pkg::ADDR_COUNT))
    begin
      count_value_d = i_wdata;
    end
    else if (tick && mode_dual)
    begin
      dir_d = dir_next;
      count_value_d = next_up ? count_value_q + 16'h0001 : count_value_q - 16'h0001;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      count_value_q <= dsp_pkg::VALUE_RST;
      dir_q <= dsp_pkg::DSP_DIR_UP;
    end
    else
    begin
      count_value_q <= count_value_d;
      dir_q <= dir_d;
    end
  end

  //----------------------------------------------------------------
  // Compare channels
  //----------------------------------------------------------------
  dsp_channel u_chan_a
  (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_tick(tick),
    .i_dual(mode_dual),
    .i_count(count_value_q),
    .i_compare(compare_value_a_q),
    .i_next_up(next_up),
    .i_action(output_action_sel_a),
    .i_toggle_ok(top_is_cmpa),
    .o_match(match_a),
    .o_compare_output(compare_output_a)
  );

  dsp_channel u_chan_b
  (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_tick(tick),
    .i_dual(mode_dual),
    .i_count(count_value_q),
    .i_compare(compare_value_b_q),
    .i_next_up(next_up),
    .i_action(output_action_sel_b),
    .i_toggle_ok(1'b0),
    .o_match(match_b),
    .o_compare_output(compare_output_b)
  );

  //----------------------------------------------------------------
  // Registers, buffers, flags and pins
  //----------------------------------------------------------------
  always_comb
  begin
    ctrl_d = ctrl_q;
    buf_a_d = buf_a_q;
    buf_b_d = buf_b_q;
    capture_top_value_d = capture_top_value_q;
    flag_clr = 4'h0;
    if (i_wr)
    begin
      case (i_addr)
        dsp_pkg::ADDR_CTRL: ctrl_d = i_wdata;
        dsp_pkg::ADDR_CMP_A: buf_a_d = i_wdata & write_mask;
        dsp_pkg::ADDR_CMP_B: buf_b_d = i_wdata & write_mask;
        dsp_pkg::ADDR_CAP_TOP: capture_top_value_d = i_wdata;
        dsp_pkg::ADDR_FLAGS: flag_clr = i_wdata[dsp_pkg::FLAG_W-1:0];
        default: ctrl_d = ctrl_q;
      endcase
    end
    // Phase correct loads at top, so its period runs top to top.
    load = tick && ((mode_pc && at_top) || (mode_pfc && at_bottom));
    compare_value_a_d = compare_value_a_q;
    compare_value_b_d = compare_value_b_q;
    if (load || !mode_dual)
    begin
      compare_value_a_d = buf_a_q;
      compare_value_b_d = buf_b_q;
    end
    flag_set = 4'h0;
    flag_set[dsp_pkg::FLAG_OVF] = tick && mode_dual && at_bottom;
    flag_set[dsp_pkg::FLAG_CMP_A] = match_a || (tick && top_is_cmpa && at_top);
    flag_set[dsp_pkg::FLAG_CMP_B] = match_b;
    flag_set[dsp_pkg::FLAG_CAP] = tick && top_is_cap && at_top;
    flags_d = (flags_q & ~flag_clr) | flag_set;
    pin_a_d = (output_action_sel_a == dsp_pkg::ACT_OFF) ? ctrl_q[dsp_pkg::CTRL_PORT_A] : compare_output_a;
    pin_b_d = (output_action_sel_b == dsp_pkg::ACT_OFF) ? ctrl_q[dsp_pkg::CTRL_PORT_B] : compare_output_b;
    rdata_d = 16'h0000;
    if (i_rd)
    begin
      case (i_addr)
        dsp_pkg::ADDR_CTRL: rdata_d = ctrl_q;
        dsp_pkg::ADDR_COUNT: rdata_d = count_value_q;
        dsp_pkg::ADDR_CMP_A: rdata_d = buf_a_q;
        dsp_pkg::ADDR_CMP_B: rdata_d = buf_b_q;
        dsp_pkg::ADDR_CAP_TOP: rdata_d = capture_top_value_q;
        dsp_pkg::ADDR_FLAGS: rdata_d = {12'h000, flags_q};
        dsp_pkg::ADDR_STATUS: rdata_d = {13'h0000, compare_output_b, compare_output_a, dir_q == dsp_pkg::DSP_DIR_UP};
        default: rdata_d = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      ctrl_q <= dsp_pkg::CTRL_RST;
      buf_a_q <= dsp_pkg::VALUE_RST;
      buf_b_q <= dsp_pkg::VALUE_RST;
      compare_value_a_q <= dsp_pkg::VALUE_RST;
      compare_value_b_q <= dsp_pkg::VALUE_RST;
      capture_top_value_q <= dsp_pkg::VALUE_RST;
      flags_q <= dsp_pkg::FLAGS_RST;
      o_rdata <= 16'h0000;
      o_pin_a <= 1'b0;
      o_pin_b <= 1'b0;
      o_pin_a_oe_n <= 1'b1;
      o_pin_b_oe_n <= 1'b1;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      buf_a_q <= buf_a_d;
      buf_b_q <= buf_b_d;
      compare_value_a_q <= compare_value_a_d;
      compare_value_b_q <= compare_value_b_d;
      capture_top_value_q <= capture_top_value_d;
      flags_q <= flags_d;
      o_rdata <= rdata_d;
      o_pin_a <= pin_a_d;
      o_pin_b <= pin_b_d;
      o_pin_a_oe_n <= ~ctrl_q[dsp_pkg::CTRL_DIR_A];
      o_pin_b_oe_n <= ~ctrl_q[dsp_pkg::CTRL_DIR_B];
    end
  end

endmodule

// *** verif/dsp_timer_sva.sv ***
// Concurrent checks on the ports of the dual-slope PWM timer.
`timescale 1ns/1ps

module dsp_timer_sva
(
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic [2:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [15:0] o_rdata,
  input wire logic o_pin_a,
  input wire logic o_pin_a_oe_n,
  input wire logic o_pin_b,
  input wire logic o_pin_b_oe_n
);
  logic [15:0] ctrl_q, ctrl_d, cap_q, cap_d, cmpa_q, cmpa_d, cmpb_q, cmpb_d, mask;

  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_rst);

  // ----------------------------------------
  // Shadow of the control, compare and capture top registers
  // ----------------------------------------
  always_comb
  begin
    ctrl_d = ctrl_q;
    cap_d = cap_q;
    cmpa_d = cmpa_q;
    cmpb_d = cmpb_q;
    case (ctrl_q[3:0])
      dsp_pkg::MODE_PC_8: mask = dsp_pkg::TOP_8;
      dsp_pkg::MODE_PC_9: mask = dsp_pkg::TOP_9;
      dsp_pkg::MODE_PC_10: mask = dsp_pkg::TOP_10;
      default: mask = dsp_pkg::TOP_MAX;
    endcase
    if (i_wr)
    begin
      case (i_addr)
        dsp_pkg::ADDR_CTRL: ctrl_d = i_wdata;
        dsp_pkg::ADDR_CMP_A: cmpa_d = i_wdata & mask;
        dsp_pkg::ADDR_CMP_B: cmpb_d = i_wdata & mask;
        dsp_pkg::ADDR_CAP_TOP: cap_d = i_wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      ctrl_q <= 16'h0000;
      cap_q <= 16'h0000;
      cmpa_q <= 16'h0000;
      cmpb_q <= 16'h0000;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      cap_q <= cap_d;
      cmpa_q <= cmpa_d;
      cmpb_q <= cmpb_d;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_rdata_idle: assert property (!i_rd |=> o_rdata == 16'h0000)
    else $error("read data not zero outside a read answer");
  a_unmapped_zero: assert property (i_rd && i_addr == 3'h7 |=> o_rdata == 16'h0000)
    else $error("unmapped index did not read zero");
  a_ctrl_readback: assert property (i_rd && i_addr == dsp_pkg::ADDR_CTRL |=> o_rdata[14:0] == $past(ctrl_q[14:0]))
    else $error("control read does not match last write");
  a_cmp_masked: assert property (i_rd && i_addr[2:1] == 2'h1 |=>
    o_rdata == (($past(i_addr) == dsp_pkg::ADDR_CMP_A) ? $past(cmpa_q) : $past(cmpb_q)))
    else $error("compare read does not match masked write");
  a_cap_direct: assert property (i_rd && i_addr == dsp_pkg::ADDR_CAP_TOP |=> o_rdata == $past(cap_q))
    else $error("capture top read does not match last write");
  a_oe_a_dir: assert property (o_pin_a_oe_n == !$past(ctrl_q[dsp_pkg::CTRL_DIR_A]))
    else $error("pin A enable does not follow its direction bit");
  a_oe_b_dir: assert property (o_pin_b_oe_n == !$past(ctrl_q[dsp_pkg::CTRL_DIR_B]))
    else $error("pin B enable does not follow its direction bit");
  a_port_a_value: assert property ($past(ctrl_q[5:4]) == dsp_pkg::ACT_OFF |->
    o_pin_a == $past(ctrl_q[dsp_pkg::CTRL_PORT_A]))
    else $error("pin A not under port control with action off");
  a_port_b_value: assert property ($past(ctrl_q[7:6]) == dsp_pkg::ACT_OFF |->
    o_pin_b == $past(ctrl_q[dsp_pkg::CTRL_PORT_B]))
    else $error("pin B not under port control with action off");
endmodule

// *** verif/dsp_pin_model.sv ***
// Port pin model: resolves the wire level and measures run lengths.
`timescale 1ns/1ps

module dsp_pin_model
(
  input wire logic i_ref_clk,
  input wire logic i_pin,
  input wire logic i_pin_oe_n,
  output logic o_level,
  output logic [19:0] o_run,
  output logic [19:0] o_high_len,
  output logic [19:0] o_low_len
);
  logic last_q = 1'b0;

  // A released pin has no keeper, so it shows a level that flips every cycle.
  assign o_level = i_pin_oe_n ? ~last_q : i_pin;

  initial
  begin
    o_run = 20'h00000;
    o_high_len = 20'h00000;
    o_low_len = 20'h00000;
  end

  always @(posedge i_ref_clk)
  begin
    last_q <= o_level;
    if (o_level === last_q)
      o_run <= o_run + 20'h00001;
    else
    begin
      if (last_q)
        o_high_len <= o_run;
      else
        o_low_len <= o_run;
      o_run <= 20'h00001;
    end
  end
endmodule

// *** verif/dsp_timer_tb.sv ***
// Self-checking bench for the dual-slope PWM timer.
`timescale 1ns/1ps

`define CHK(got, exp) \
  begin \
    cmp_count++; \
    if ((got) !== (exp)) \
    begin \
      errors++; \
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp); \
    end \
  end

module dsp_timer_tb;
  logic i_ref_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [2:0] i_addr = 3'h0;
  logic [15:0] i_wdata = 16'h0000;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [15:0] o_rdata;
  logic o_pin_a, o_pin_a_oe_n, o_pin_b, o_pin_b_oe_n, lvl_a, lvl_b, tg, rd_d = 1'b0;
  logic [19:0] run_a, run_b, hi_a, hi_b, lo_a, lo_b;
  logic [15:0] exp_q[$];
  logic [15:0] msk_q[$];
  logic [15:0] t, ca, cb, e_v, m_v;
  logic [7:0] seed = 8'h5E;
  logic [3:0] m;
  logic [2:0] pre;
  logic [1:0] act;
  logic [3:0] mode_tab [11] = '{4'h1, 4'h2, 4'h3, 4'hA, 4'hB, 4'h8, 4'h9, 4'hA, 4'hA, 4'hA, 4'hA};
  int errors = 0;
  int cmp_count = 0;
  int dv, p;

  initial
  begin
    forever #10 i_ref_clk = ~i_ref_clk;
  end

  dsp_timer DUT (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .o_pin_a(o_pin_a), .o_pin_a_oe_n(o_pin_a_oe_n), .o_pin_b(o_pin_b),
    .o_pin_b_oe_n(o_pin_b_oe_n));
  dsp_pin_model u_pin_a (.i_ref_clk(i_ref_clk), .i_pin(o_pin_a), .i_pin_oe_n(o_pin_a_oe_n), .o_level(lvl_a),
    .o_run(run_a), .o_high_len(hi_a), .o_low_len(lo_a));
  dsp_pin_model u_pin_b (.i_ref_clk(i_ref_clk), .i_pin(o_pin_b), .i_pin_oe_n(o_pin_b_oe_n), .o_level(lvl_b),
    .o_run(run_b), .o_high_len(hi_b), .o_low_len(lo_b));

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  function automatic logic [15:0] fixed_top(input logic [3:0] md);
    case (md)
      dsp_pkg::MODE_PC_8: return dsp_pkg::TOP_8;
      dsp_pkg::MODE_PC_9: return dsp_pkg::TOP_9;
      dsp_pkg::MODE_PC_10: return dsp_pkg::TOP_10;
      default: return dsp_pkg::TOP_MAX;
    endcase
  endfunction

  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge i_ref_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, input logic [15:0] e, input logic [15:0] mk);
    @(posedge i_ref_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    exp_q.push_back(e & mk);
    msk_q.push_back(mk);
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
  endtask

  task automatic waitc(input int n);
    repeat (n) @(posedge i_ref_clk);
    @(negedge i_ref_clk);
  endtask

  task automatic end_sim;
    $display("Compares %0d, mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // ----------------------------------------
  // Read answer monitor
  // ----------------------------------------
  always @(posedge i_ref_clk)
    rd_d <= i_rd;

  always @(negedge i_ref_clk)
  begin
    if (rd_d && exp_q.size() > 0)
    begin
      e_v = exp_q.pop_front();
      m_v = msk_q.pop_front();
      `CHK(o_rdata & m_v, e_v)
    end
  end

  initial
  begin
    repeat (80000) @(posedge i_ref_clk);
    errors++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    end_sim();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    repeat (20) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    for (int a = 0; a < 8; a++)
      rd(3'(a), 16'h0000, (a == 6) ? 16'hFFFE : 16'hFFFF);
    $display("Test reset values done");
    for (int i = 0; i < 4; i++)
    begin
      m = (i == 3) ? 4'hA : 4'(i + 1);
      wr(dsp_pkg::ADDR_CTRL, {12'h000, m});
      wr(dsp_pkg::ADDR_CMP_A, 16'hABCD);
      wr(dsp_pkg::ADDR_CMP_B, 16'hFFFF);
      rd(dsp_pkg::ADDR_CMP_A, 16'hABCD & fixed_top(m), 16'hFFFF);
      rd(dsp_pkg::ADDR_CMP_B, fixed_top(m), 16'hFFFF);
    end
    $display("Test compare write mask done");
    for (int i = 0; i < 11; i++)
    begin
      m = mode_tab[i];
      pre = (i < 7) ? dsp_pkg::PRE_DIV_1 : 3'(i - 5);
      dv = (i < 7) ? 1 : (i == 7) ? 8 : 16 << (2 * (i - 7));
      seed = lfsr(seed);
      t = fixed_top(m);
      if (t == dsp_pkg::TOP_MAX)
        t = 16'h0008 + {11'h000, seed[4:0]};
      // The slow dividers use the smallest legal top so the run stays short.
      if (i > 7)
        t = 16'h0003;
      tg = (m == dsp_pkg::MODE_PC_CMPA) || (m == dsp_pkg::MODE_PFC_CMPA);
      ca = tg ? t : (t >> 2) | 16'h0001;
      cb = t >> 1;
      p = 2 * int'(t) * dv;
      wr(dsp_pkg::ADDR_CTRL, 16'h0000);
      wr(dsp_pkg::ADDR_COUNT, 16'h0000);
      wr(dsp_pkg::ADDR_CAP_TOP, t);
      rd(dsp_pkg::ADDR_CAP_TOP, t, 16'hFFFF);
      wr(dsp_pkg::ADDR_CMP_A, ca);
      wr(dsp_pkg::ADDR_CMP_B, cb);
      act = tg ? dsp_pkg::ACT_TOGGLE : dsp_pkg::ACT_INV;
      wr(dsp_pkg::ADDR_CTRL, {1'b0, pre, 4'h3, dsp_pkg::ACT_NONINV, act, m});
      waitc(3 * p + 8);
      `CHK(hi_b, 20'(2 * int'(cb) * dv))
      `CHK(lo_b, 20'(p - 2 * int'(cb) * dv))
      `CHK(hi_a, 20'(tg ? p : p - 2 * int'(ca) * dv))
      `CHK(lo_a, 20'(tg ? p : 2 * int'(ca) * dv))
      wr(dsp_pkg::ADDR_FLAGS, 16'h000F);
      waitc(p + 4);
      rd(dsp_pkg::ADDR_FLAGS, {12'h000, m == 4'hA || m == 4'h8, 3'h7}, 16'h000F);
      $display("Test mode %h done", m);
    end
    for (int k = 0; k < 2; k++)
    begin
      wr(dsp_pkg::ADDR_CTRL, 16'h0000);
      wr(dsp_pkg::ADDR_COUNT, 16'h0000);
      wr(dsp_pkg::ADDR_CAP_TOP, 16'h0010);
      wr(dsp_pkg::ADDR_CMP_A, 16'h0010);
      wr(dsp_pkg::ADDR_CMP_B, 16'h0000);
      act = (k == 1) ? dsp_pkg::ACT_INV : dsp_pkg::ACT_NONINV;
      wr(dsp_pkg::ADDR_CTRL, {1'b0, dsp_pkg::PRE_DIV_1, 4'h3, act, act, dsp_pkg::MODE_PC_CAP});
      waitc(200);
      `CHK(lvl_a, 1'(k == 0))
      `CHK(lvl_b, 1'(k == 1))
      `CHK(run_a > 20'h00040 && run_b > 20'h00040, 1'b1)
      rd(dsp_pkg::ADDR_STATUS, {13'h0000, 1'(k == 1), 1'(k == 0), 1'b0}, 16'h0006);
    end
    $display("Test extreme compare values done");
    wr(dsp_pkg::ADDR_CTRL, 16'h0700);
    waitc(3);
    `CHK(lvl_a, 1'b1)
    `CHK(lvl_b, 1'b0)
    wr(dsp_pkg::ADDR_CTRL, 16'h0000);
    waitc(3);
    `CHK(o_pin_a_oe_n & o_pin_b_oe_n, 1'b1)
    $display("Test port control done");
    end_sim();
  end
endmodule

bind dsp_timer dsp_timer_sva u_sva (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_pin_a(o_pin_a), .o_pin_a_oe_n(o_pin_a_oe_n),
  .o_pin_b(o_pin_b), .o_pin_b_oe_n(o_pin_b_oe_n));
